/* File: hw/tx_fifo_write_clock_select.sv */
// transmitter phase compensation fifo with write and read clock selection
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - In x4 bonding all four channels write the fifo on the bonded core clock.
// - In x8 bonding all eight channels write the fifo on the master block's core clock.
// - Non-bonded identical channels in a block share one channel clock output as write clock.
// - An enabled user write-clock input overrides the default choice for that channel.
// - Non-bonded read clock is the local divider clock, halved with byte serialization.
// - x4 read clock is the block's first multiplier divider clock, halved with serialization.
// - x8 read clock is the master block's first multiplier divider clock, halved likewise.
// - Each channel forwards its channel clock, or the core clock when bonded, to fabric.

// ----------------------------------------------------------------
// fifo
// ----------------------------------------------------------------
module tx_phase_fifo #(
  parameter int unsigned W = 32,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  // fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == LAST_C) ? '0 : p + 1'b1;
  endfunction

  // honest full and empty, back-pressure reaches the source
  assign in_ready = (count_q != DEPTH_C);
  assign out_valid = (count_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_q];
  assign level = count_q;

  // storage has no reset, only pointers and count do
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= bump(wr_ptr_q);
      end
      if (pop)
      begin
        rd_ptr_q <= bump(rd_ptr_q);
      end
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------------------------------
// clock-select top
// ----------------------------------------------------------------
module tx_fifo_write_clock_select #(
  parameter int unsigned NUM_CH = 4,
  parameter int unsigned DATA_W = txclk_pkg::FIFO_W,
  parameter int unsigned DEPTH = txclk_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [txclk_pkg::APB_AW-1:0] PADDR,
  input wire logic [txclk_pkg::APB_DW-1:0] PWDATA,
  output logic [txclk_pkg::APB_DW-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // fabric write side
  input wire logic [DATA_W-1:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  // pcs read side
  output logic [DATA_W-1:0] PCS_DATA,
  output logic PCS_VALID,
  input wire logic PCS_READY,
  // clock selection, two bits per channel, plus one shared read divide-by-two bit
  output logic [2*NUM_CH-1:0] WR_CLK_SEL,
  output logic [2*NUM_CH-1:0] WR_CLK_LEAD,
  output logic [2*NUM_CH-1:0] RD_CLK_SEL,
  output logic [2*NUM_CH-1:0] FWD_CLK_SEL,
  output logic RD_CLK_DIV2
);
  import txclk_pkg::*;

  localparam int unsigned LW = $clog2(DEPTH) + 1;
  logic [1:0] mode_q;
  logic bser_q;
  logic [NUM_CH-1:0] user_en_q;
  logic [2*NUM_CH-1:0] lead_q;
  logic ovf_q;
  logic unf_q;
  logic rd_phase_q;
  logic [APB_DW-1:0] prdata_q;
  logic [2*NUM_CH-1:0] wr_sel_d;
  logic [2*NUM_CH-1:0] rd_sel_d;
  logic [2*NUM_CH-1:0] fwd_sel_d;
  logic [LW-1:0] level;
  logic fifo_valid;
  logic rd_slot;
  logic pop;
  logic setup;
  logic wr_acc;
  logic mapped;
  logic ovf_evt;
  logic unf_evt;

  // write mux: user input wins, otherwise bonding decides
  function automatic logic [1:0] wr_src(input logic [1:0] mode, input logic user);
    if (user)
      wr_src = WR_SRC_USER;
    else if (mode == MODE_X4)
      wr_src = WR_SRC_CORE;
    else if (mode == MODE_X8)
      wr_src = WR_SRC_MASTER_CORE;
    else
      wr_src = WR_SRC_CH_CLKOUT;
  endfunction

  // read clock source, independent of the user write input
  function automatic logic [1:0] rd_src(input logic [1:0] mode);
    if (mode == MODE_X4)
      rd_src = RD_SRC_MULT_ZERO;
    else if (mode == MODE_X8)
      rd_src = RD_SRC_MASTER_MULT_ZERO;
    else
      rd_src = RD_SRC_LOCAL_DIV;
  endfunction

  // apb decode; zero wait states keeps the master simple
  assign setup = PSEL && !PENABLE;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign mapped = (PADDR == OFF_CTRL) || (PADDR == OFF_USER_EN) || (PADDR == OFF_LEAD)
                  || (PADDR == OFF_STATUS) || (PADDR == OFF_SEL);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA = prdata_q;

  // control registers; reserved mode 3 behaves as non-bonded
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      mode_q <= MODE_RST;
      bser_q <= 1'b0;
      user_en_q <= '0;
      lead_q <= LEAD_RST[2*NUM_CH-1:0];
    end
    else if (wr_acc)
    begin
      if (PADDR == OFF_CTRL)
      begin
        mode_q <= PWDATA[CTRL_MODE_LSB +: 2];
        bser_q <= PWDATA[CTRL_BSER_BIT];
      end
      if (PADDR == OFF_USER_EN)
      begin
        user_en_q <= PWDATA[NUM_CH-1:0];
      end
      if (PADDR == OFF_LEAD)
      begin
        lead_q <= PWDATA[2*NUM_CH-1:0];
      end
    end
  end

  // per-channel selection
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      wr_sel_d[2*i +: 2] = wr_src(mode_q, user_en_q[i]);
      rd_sel_d[2*i +: 2] = rd_src(mode_q);
      fwd_sel_d[2*i +: 2] = wr_src(mode_q, 1'b0);
    end
  end

  // selection outputs come from flops so the clock muxes see no glitches
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      WR_CLK_SEL <= '0;
      WR_CLK_LEAD <= '0;
      RD_CLK_SEL <= '0;
      FWD_CLK_SEL <= '0;
      RD_CLK_DIV2 <= 1'b0;
    end
    else
    begin
      WR_CLK_SEL <= wr_sel_d;
      WR_CLK_LEAD <= lead_q;
      RD_CLK_SEL <= rd_sel_d;
      FWD_CLK_SEL <= fwd_sel_d;
      RD_CLK_DIV2 <= bser_q;
    end
  end

  // halved read rate: a read slot every other cycle under byte serialization
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rd_phase_q <= 1'b0;
    end
    else
    begin
      rd_phase_q <= bser_q ? !rd_phase_q : 1'b0;
    end
  end

  assign rd_slot = !bser_q || rd_phase_q;
  assign pop = PCS_VALID && PCS_READY;
  assign PCS_VALID = fifo_valid && rd_slot;

  tx_phase_fifo #(
    .W(DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .in_data(TX_DATA),
    .in_valid(TX_VALID),
    .in_ready(TX_READY),
    .out_data(PCS_DATA),
    .out_valid(fifo_valid),
    .out_ready(PCS_READY && rd_slot),
    .level(level)
  );

  // rate mismatch shows as write-while-full or read-slot-while-empty
  assign ovf_evt = TX_VALID && !TX_READY;
  assign unf_evt = PCS_READY && rd_slot && !fifo_valid;

  // sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end
    else
    begin
      if (ovf_evt)
        ovf_q <= 1'b1;
      else if (wr_acc && PADDR == OFF_STATUS && PWDATA[STAT_OVF_BIT])
        ovf_q <= 1'b0;
      if (unf_evt)
        unf_q <= 1'b1;
      else if (wr_acc && PADDR == OFF_STATUS && PWDATA[STAT_UNF_BIT])
        unf_q <= 1'b0;
    end
  end

  // read data captured in setup, presented through the access phase
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      prdata_q <= '0;
    end
    else if (setup)
    begin
      prdata_q <= '0;
      case (PADDR)
        OFF_CTRL:
        begin
          prdata_q[CTRL_MODE_LSB +: 2] <= mode_q;
          prdata_q[CTRL_BSER_BIT] <= bser_q;
        end
        OFF_USER_EN: prdata_q[NUM_CH-1:0] <= user_en_q;
        OFF_LEAD: prdata_q[2*NUM_CH-1:0] <= lead_q;
        OFF_STATUS:
        begin
          prdata_q[STAT_LVL_LSB +: LW] <= level;
          prdata_q[STAT_OVF_BIT] <= ovf_q;
          prdata_q[STAT_UNF_BIT] <= unf_q;
        end
        OFF_SEL:
        begin
          prdata_q[2*NUM_CH-1:0] <= WR_CLK_SEL;
          prdata_q[SEL_RD_LSB +: 2*NUM_CH] <= RD_CLK_SEL;
        end
        default: prdata_q <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_chk
    a_user_override: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      user_en_q[g] |=> WR_CLK_SEL[2*g +: 2] == WR_SRC_USER)
      else $error("user write clock not selected");
    a_x4_core_sel: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (mode_q == MODE_X4 && !user_en_q[g]) |=> WR_CLK_SEL[2*g +: 2] == WR_SRC_CORE)
      else $error("x4 write clock not core clock");
    a_x8_master_sel: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (mode_q == MODE_X8 && !user_en_q[g]) |=> WR_CLK_SEL[2*g +: 2] == WR_SRC_MASTER_CORE)
      else $error("x8 write clock not master core clock");
    a_nb_shared_lead: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (mode_q == MODE_NB && !user_en_q[g])
      |=> WR_CLK_SEL[2*g +: 2] == WR_SRC_CH_CLKOUT && WR_CLK_LEAD == $past(lead_q))
      else $error("non-bonded write clock not shared channel clock");
    a_default_mux: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      !user_en_q[g] |=> WR_CLK_SEL[2*g +: 2] == FWD_CLK_SEL[2*g +: 2])
      else $error("default write clock differs from forwarded clock");
    a_rd_source: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (mode_q == MODE_X4) [*2] |-> RD_CLK_SEL[2*g +: 2] == RD_SRC_MULT_ZERO)
      else $error("x4 read clock not first multiplier divider");
    a_rd_master_x8: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (mode_q == MODE_X8) [*2] |-> RD_CLK_SEL[2*g +: 2] == RD_SRC_MASTER_MULT_ZERO)
      else $error("x8 read clock not master first multiplier divider");
    a_fwd_bonded: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (mode_q == MODE_X8) |=> FWD_CLK_SEL[2*g +: 2] == WR_SRC_MASTER_CORE)
      else $error("bonded channel does not forward core clock");
  end

  a_rd_local_nb: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (mode_q == MODE_NB) |=> RD_CLK_SEL[1:0] == RD_SRC_LOCAL_DIV && RD_CLK_DIV2 == $past(bser_q))
    else $error("non-bonded read clock wrong");
  a_half_rate: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (bser_q && $past(bser_q) && pop) |=> !pop)
    else $error("read faster than half rate");
  a_ovf_sticky: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (ovf_evt ##1 !(wr_acc && PADDR == OFF_STATUS && PWDATA[STAT_OVF_BIT])) |-> ovf_q ##1 ovf_q)
    else $error("overflow flag lost");
  a_unf_sticky: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    unf_evt |=> unf_q)
    else $error("underrun flag lost");
endmodule

/* File: hw/txclk_pkg.sv */
// shared constants for the transmitter fifo clock-select block
package txclk_pkg;
  // apb geometry
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_USER_EN = 12'h004;
  localparam logic [11:0] OFF_LEAD = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_SEL = 12'h010;
  // ctrl fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_BSER_BIT = 2;
  // status fields
  localparam int unsigned STAT_LVL_LSB = 0;
  localparam int unsigned STAT_OVF_BIT = 8;
  localparam int unsigned STAT_UNF_BIT = 9;
  // sel readback fields
  localparam int unsigned SEL_RD_LSB = 16;
  // bonding modes
  localparam logic [1:0] MODE_NB = 2'h0;
  localparam logic [1:0] MODE_X4 = 2'h1;
  localparam logic [1:0] MODE_X8 = 2'h2;
  // write-clock source codes
  localparam logic [1:0] WR_SRC_CH_CLKOUT = 2'h0;
  localparam logic [1:0] WR_SRC_CORE = 2'h1;
  localparam logic [1:0] WR_SRC_MASTER_CORE = 2'h2;
  localparam logic [1:0] WR_SRC_USER = 2'h3;
  // read-clock source codes
  localparam logic [1:0] RD_SRC_LOCAL_DIV = 2'h0;
  localparam logic [1:0] RD_SRC_MULT_ZERO = 2'h1;
  localparam logic [1:0] RD_SRC_MASTER_MULT_ZERO = 2'h2;
  // reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [31:0] LEAD_RST = 32'h0000_0000;
  // data path
  localparam int unsigned FIFO_W = 32;
  localparam int unsigned FIFO_DEPTH = 16;
endpackage

/* File: tb/fabric_model.sv */
// behavioural fabric writer feeding the transmitter fifo
`timescale 1ns/1ps
module fabric_model (
  // clock, shared with the fifo read side
  input wire logic clk,
  // write handshake
  input wire logic ready,
  output logic [31:0] data,
  output logic valid
);
  logic [31:0] q[$];
  initial
  begin
    valid = 1'b0;
    data = 32'h0;
  end
  // same clock as reads, so no ppm drift is possible
  always @(posedge clk)
  begin
    if (valid && ready)
    begin
      void'(q.pop_front());
    end
    valid <= q.size() > 0;
    // an idle bus inverts its value every cycle, so the inverse of the last word and the word itself alternate
    data <= (q.size() > 0) ? q[0] : ~data;
  end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the fifo clock-select block
`timescale 1ns/1ps
module testbench;
  import txclk_pkg::*;
  logic REF_CLK, RESET_N, PSEL, PENABLE, PWRITE, PCS_READY, TX_VALID, TX_READY;
  logic PREADY, PSLVERR, PCS_VALID, RD_CLK_DIV2;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, TX_DATA, PCS_DATA, r, expq[$];
  logic [7:0] WR_CLK_SEL, WR_CLK_LEAD, RD_CLK_SEL, FWD_CLK_SEL;
  logic e, bser, prev;
  logic [3:0] ue;
  logic [7:0] ld;
  int fails, tests_run, cyc;

  tx_fifo_write_clock_select i_tx_fifo_write_clock_select (.REF_CLK(REF_CLK),
    .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .PCS_DATA(PCS_DATA), .PCS_VALID(PCS_VALID), .PCS_READY(PCS_READY),
    .WR_CLK_SEL(WR_CLK_SEL), .WR_CLK_LEAD(WR_CLK_LEAD), .RD_CLK_SEL(RD_CLK_SEL),
    .FWD_CLK_SEL(FWD_CLK_SEL), .RD_CLK_DIV2(RD_CLK_DIV2));
  fabric_model i_fabric_model (.clk(REF_CLK), .ready(TX_READY), .data(TX_DATA),
    .valid(TX_VALID));

  initial
  begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x)
    begin
      $display("wrong value %s exp %h got %h", n, x, g);
      fails++;
    end
  endtask

  task close_out;
    $display("mismatches %0d checks %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one apb transfer; entered just after a rising edge, ends one idle cycle later
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1)
      @(posedge REF_CLK);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask

  // pushes random words into the writer and the expected queue, off the edge
  task push(input int n);
    logic [31:0] w;
    @(negedge REF_CLK);
    repeat (n)
    begin
      w = $urandom;
      i_fabric_model.q.push_back(w);
      expq.push_back(w);
    end
    @(posedge REF_CLK);
  endtask

  // expected write code: user wins, else core clocks when bonded
  function automatic logic [7:0] ewr(int m, logic [3:0] u);
    logic [7:0] v;
    for (int c = 0; c < 4; c++)
      v[2*c+:2] = u[c] ? WR_SRC_USER : (m == 1) ? WR_SRC_CORE :
        (m == 2) ? WR_SRC_MASTER_CORE : WR_SRC_CH_CLKOUT;
    return v;
  endfunction

  function automatic logic [7:0] erd(int m);
    return {4{(m == 1) ? RD_SRC_MULT_ZERO : (m == 2) ? RD_SRC_MASTER_MULT_ZERO :
      RD_SRC_LOCAL_DIV}};
  endfunction

  // pcs side monitor: order of words, and no back-to-back pops when halved
  always @(posedge REF_CLK)
  begin
    if (PCS_VALID && PCS_READY)
    begin
      chk("pcs_data", expq.pop_front(), PCS_DATA);
      if (bser && prev)
        chk("pop_spacing", 32'h0, 32'h1);
    end
    prev <= PCS_VALID && PCS_READY;
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      close_out;
    end
  end

  initial
  begin
    {PSEL, PENABLE, PWRITE, PCS_READY, bser, prev} = 6'h0;
    PADDR = 12'h0;
    PWDATA = 32'h0;
    fails = 0;
    tests_run = 0;
    cyc = 0;
    RESET_N = 1'b0;
    void'($urandom(32'h7766e17d));
    repeat (2) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    @(posedge REF_CLK);
    apb(1'b0, OFF_LEAD, 32'h0);
    chk("lead_rst", LEAD_RST, r);
    // every mode, with and without the byte serializer
    for (int m = 0; m < 4; m++)
      for (int b = 0; b < 2; b++)
      begin
        ue = (b == 0) ? 4'h0 : 4'($urandom);
        ld = 8'($urandom);
        apb(1'b1, OFF_USER_EN, {28'h0, ue});
        apb(1'b1, OFF_LEAD, {24'h0, ld});
        apb(1'b1, OFF_CTRL, {29'h0, b[0], m[1:0]});
        @(negedge REF_CLK);
        chk("wr_sel", ewr(m, ue), WR_CLK_SEL);
        chk("rd_sel", erd(m), RD_CLK_SEL);
        chk("fwd_sel", ewr(m, 4'h0), FWD_CLK_SEL);
        chk("div2", b, RD_CLK_DIV2);
        if (m == 0 && b == 0)
          chk("lead", ld, WR_CLK_LEAD);
        @(posedge REF_CLK);
        apb(1'b0, OFF_SEL, 32'h0);
        chk("sel_rb", {8'h0, erd(m), 8'h0, ewr(m, ue)}, r);
      end
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped_err", 32'h1, e);
    chk("unmapped_data", 32'h0, r);
    // fill past full with the pcs stalled, then drain into underrun
    apb(1'b1, OFF_CTRL, 32'h0);
    push(17);
    repeat (25) @(posedge REF_CLK);
    chk("tx_ready", 32'h0, TX_READY);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("stat_full", 32'h110, r & 32'h3ff);
    PCS_READY <= 1'b1;
    repeat (25) @(posedge REF_CLK);
    chk("drained", 32'h0, expq.size());
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("stat_empty", 32'h300, r & 32'h3ff);
    PCS_READY <= 1'b0;
    apb(1'b1, OFF_STATUS, 32'h300);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("stat_clr", 32'h0, r & 32'h3ff);
    // halved read clock: pops come at most every other cycle
    apb(1'b1, OFF_CTRL, 32'h4);
    bser = 1'b1;
    PCS_READY <= 1'b1;
    push(6);
    repeat (20) @(posedge REF_CLK);
    chk("drained_bser", 32'h0, expq.size());
    close_out;
  end
endmodule
